// ---- bench/mfe_host_model.sv ----
/*
  Serial host model for the front end configuration port: one-byte frames, MSB first.
  Assumes a free clk; pin changes land on falling clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mfe_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic sen_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic drv_r = 1'b0;
  initial begin
    sclk = 1'b0;
    sen_n = 1'b1;
  end
  // Released line shows inverse of last bit, not a stale copy
  assign sdio_in = sdio_oe ? sdio_out : drv_r;
  task automatic xfer(input logic rd, input logic [4:0] adr, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    // zero count field, caller masks data
    sh = {rd, 2'b00, adr, wd};
    rdat = 8'h00;
    @(negedge clk);
    sen_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!rd || i > 7) drv_r = sh[i];
      else if (i == 7) drv_r = ~drv_r;
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      if (i < 8) rdat[i] = sdio_out;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    sen_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : mfe_host_model
`default_nettype wire

// ---- bench/tb_modem_frontend_config_regs.sv ----
/*
  Self-checking bench of the front end configuration block.
  Assumes the package and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_modem_frontend_config_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_pin = 1'b0, config_pin = 1'b0, pd_pin = 1'b0, dir_in = 1'b1;
  logic tx_en = 1'b0, quiet = 1'b0, gain_s = 1'b0, ready = 1'b0, rqc = 1'b0, rso;
  logic sclk, sen_n, sdio_in, sdio_out, sdio_oe, valid, ovf, fast_pd, tx_pd, rx_pd, aux1, aux2, rck, rck_oe, dso;
  logic [11:0] data_in = 12'h000, data_oe, dout;
  logic [5:0] gain_in = 6'h00, rx_gain, tx_gain;
  logic [9:0] tx_word, w0, rxw = 10'h2b5;
  logic [7:0] pll, rd, wv;
  mfe_pkg::mfe_pd_s bpd;
  logic [15:0] seed = 16'h145d;
  int n_mismatch = 0, checks = 0, a, n, na[3];
  always #20 clk = ~clk;
  mfe_host_model u_host (.clk(clk), .sclk(sclk), .sen_n(sen_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe));
  mfe_config u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .mode_pin(mode_pin), .config_pin(config_pin),
    .power_down_pin(pd_pin), .sclk(sclk), .sen_n(sen_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .sdo_out(), .sdo_oe(), .data_in(data_in), .data_out(dout), .data_oe(data_oe),
    .dir_sync_in(dir_in), .dir_sync_out(rso), .dir_sync_oe(dso), .tx_enable_sync_in(tx_en),
    .sample_clk_quiet_in(quiet), .receive_clock_pin_in(rqc), .receive_clock_pin_out(rck),
    .receive_clock_pin_oe(rck_oe), .gain_strobe_in(gain_s), .receive_gain_port(gain_in),
    .tx_word(tx_word), .tx_word_valid(valid), .tx_word_ready(ready), .rx_word(rxw),
    .rx_word_valid(1'b1), .rx_gain(rx_gain), .tx_gain(tx_gain), .tx_overflow(ovf),
    .block_power_down(bpd), .fast_transmit_power_down(fast_pd), .tx_path_power_down(tx_pd),
    .rx_path_power_down(rx_pd), .pll_control(pll), .first_aux_clock(aux1), .second_aux_clock(aux2));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] dflt(input logic m, input logic c, input int r);
    case (r)
      2: return (m & c) ? 8'hff : 8'h7f;
      3: return 8'hff;
      4: return (!m & c) ? 8'h02 : 8'h01;
      5: return (m & c) ? 8'h04 : 8'h00;
      6: return (m & c) ? 8'h55 : 8'h44;
      default: return 8'h00;
    endcase
  endfunction : dflt
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic reset_dut;
    rst_n = 1'b0;
    tick(20);
    rst_n = 1'b1;
    tick(4);
  endtask : reset_dut
  task automatic rises;
    logic [2:0] p, c;
    na = '{0, 0, 0};
    p = {aux1, aux2, rck};
    for (int i = 0; i < 256; i++) begin
      tick(1);
      c = {aux1, aux2, rck};
      for (int j = 0; j < 3; j++) na[j] += int'(c[j] & !p[j]);
      p = c;
    end
  endtask : rises
  task automatic nib(input logic s, input logic g, input logic [5:0] v);
    tx_en = s;
    gain_s = g;
    data_in[11:6] = v;
    tick(2);
  endtask : nib
  task automatic hd_push(input logic [9:0] w);
    data_in[11:2] = w;
    quiet = 1'b1;
    tick(4);
    quiet = 1'b0;
    tick(4);
  endtask : hd_push
  initial begin
    for (int k = 0; k < 4; k++) begin
      mode_pin = k[1];
      config_pin = k[0];
      reset_dut;
      for (int r = 0; r < 7; r++) begin
        u_host.xfer(1'b1, r[4:0], 8'h00, rd);
        if (r != 3 || k < 2) check("reg", rd, dflt(k[1], k[0], r));
      end
      check("pll", pll, dflt(k[1], k[0], 4));
      check("pd_low", bpd, 8'h00);
      pd_pin = 1'b1;
      tick(6);
      check("pd_high", bpd, dflt(k[1], k[0], 2));
      pd_pin = 1'b0;
      check("data_oe", data_oe, k[1] ? 12'h03f : 12'hffc);
      check("sync_oe", dso, k[1]);
      check("rclk_oe", rck_oe, k[1]);
    end
    $display("defaults done");
    config_pin = 1'b0;
    reset_dut;
    for (int k = 0; k < 4; k++) begin
      u_host.xfer(1'b0, mfe_pkg::REG_AUXCLK, {k[1:0], 2'b00, k[1:0], 2'b00}, rd);
      rises;
      check("aux1", 16'(na[2]), 16'(64 >> k));
      check("aux2", 16'(na[1]), 16'(128 >> (k > 2 ? 2 : k)));
      check("rclk", 16'(na[0]), 16'h0080);
    end
    u_host.xfer(1'b0, mfe_pkg::REG_AUXCLK, 8'h11, rd);
    rises;
    check("aux_off", 16'(na[2] + na[1]), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      a = 1 + seed[15:8] % 6;
      wv = seed[7:0] & (a == 4 ? 8'h3f : a == 5 ? 8'h07 : 8'hff);
      u_host.xfer(1'b0, a[4:0], wv, rd);
      u_host.xfer(1'b1, a[4:0], 8'h00, rd);
      check("rw", rd, wv);
    end
    // Both pins high so the reload picks the exceptional set
    config_pin = 1'b1;
    u_host.xfer(1'b0, mfe_pkg::REG_OPTIONS, 8'h20, rd);
    u_host.xfer(1'b1, mfe_pkg::REG_AUXCLK, 8'h00, rd);
    check("swr_aux", rd, dflt(1'b1, 1'b1, 6));
    u_host.xfer(1'b1, mfe_pkg::REG_OPTIONS, 8'h00, rd);
    check("swr_opt", rd, 8'h00);
    $display("registers done");
    ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      nib(1'b1, 1'b0, seed[5:0]);
      nib(1'b0, 1'b0, seed[11:6]);
      for (n = 0; n < 40 && valid !== 1'b1; n++) tick(1);
      if (n == 40) begin
        n_mismatch++;
        wrap_up;
      end
      check("fd_word", tx_word, {seed[5:0], seed[11:8]});
      for (int j = 0; j < 2; j++) begin
        check("fd_rx", dout[5:0], rso ? rxw[9:4] : {rxw[3:0], 2'b00});
        tick(2);
      end
      tick(4);
    end
    nib(1'b0, 1'b1, seed[15:10]);
    gain_s = 1'b0;
    gain_in = seed[9:4];
    quiet = 1'b1;
    tick(6);
    check("tx_gain", tx_gain, seed[15:10]);
    check("rx_gain", rx_gain, seed[9:4]);
    check("quiet", fast_pd, 1'b1);
    quiet = 1'b0;
    mode_pin = 1'b0;
    dir_in = 1'b0;
    ready = 1'b0;
    reset_dut;
    tx_en = 1'b1;
    seed = lfsr(seed);
    w0 = seed[9:0];
    hd_push(w0);
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      hd_push(seed[9:0]);
    end
    check("ovf", ovf, 1'b1);
    check("hd_word", tx_word, w0);
    ready = 1'b1;
    for (n = 0; n < 40 && valid === 1'b1; n++) tick(1);
    check("drain", 16'(n), 16'(mfe_pkg::FIFO_DEPTH + 1));
    rxw = seed[15:6];
    rqc = 1'b1;
    tick(6);
    check("hd_rx", dout[11:2], rxw);
    rqc = 1'b0;
    tick(8);
    check("rx_pd_on", rx_pd, 1'b1);
    check("tx_pd_on", tx_pd, 1'b0);
    tx_en = 1'b0;
    tick(121);
    check("tx_pd_early", tx_pd, 1'b0);
    tick(19);
    check("tx_pd_late", tx_pd, 1'b1);
    check("rx_pd_off", rx_pd, 1'b0);
    $display("data port done");
    wrap_up;
  end
endmodule : tb_modem_frontend_config_regs
`default_nettype wire

// ---- common/mfe_pkg.sv ----
/*
  Shared constants and types of the modem front end configuration block:
  register offsets, field positions, power-up values and the pin clocking ratios.
  Assumes every user writes package::name; nothing is imported.
*/
`default_nettype none
package mfe_pkg;
  // Register offsets on the serial port
  localparam logic [4:0] REG_OPTIONS = 5'h00;
  localparam logic [4:0] REG_PD_LOW = 5'h01;
  localparam logic [4:0] REG_PD_HIGH = 5'h02;
  localparam logic [4:0] REG_HD_POWER = 5'h03;
  localparam logic [4:0] REG_PLL = 5'h04;
  localparam logic [4:0] REG_RECEIVE_CLOCK_PIN = 5'h05;
  localparam logic [4:0] REG_AUXCLK = 5'h06;
  localparam int NUM_REGS = 7;
  // Field positions
  localparam int OPT_FOUR_WIRE = 7;
  localparam int OPT_LSB_FIRST = 6;
  localparam int OPT_SW_RESET = 5;
  localparam int HDP_DELAY_LO = 3;
  localparam int HDP_RX_BY_TRANSMIT_PATH_ENABLE = 2;
  localparam int HDP_TX_PD = 1;
  localparam int HDP_RX_PD = 0;
  localparam int RXO_OSC_ROUTE = 2;
  localparam int RXO_INVERT = 1;
  localparam int RXO_DISABLE = 0;
  localparam int AUX2_DIV_LO = 6;
  localparam int AUX2_INVERT = 5;
  localparam int AUX2_DISABLE = 4;
  localparam int AUX1_DIV_LO = 2;
  localparam int AUX1_INVERT = 1;
  localparam int AUX1_DISABLE = 0;
  // Power-up values
  localparam logic [7:0] DEF_ZERO = 8'h00;
  localparam logic [7:0] DEF_PD_HIGH = 8'h7f;
  localparam logic [7:0] DEF_PD_HIGH_ALL = 8'hff;
  localparam logic [7:0] DEF_HD_POWER = 8'hff;
  localparam logic [7:0] DEF_PLL = 8'h01;
  localparam logic [7:0] DEF_PLL_HD_CFG = 8'h02;
  localparam logic [7:0] DEF_RECEIVE_CLOCK_PIN_ALL = 8'h04;
  localparam logic [7:0] DEF_AUX = 8'h44;
  localparam logic [7:0] DEF_AUX_ALL = 8'h55;
  // Writable bits; undefined bits store and read as zero
  localparam logic [7:0] MASK_OPTIONS = 8'he0;
  localparam logic [7:0] MASK_PLL = 8'h3f;
  localparam logic [7:0] MASK_RECEIVE_CLOCK_PIN = 8'h07;
  localparam logic [7:0] MASK_FULL = 8'hff;
  // Clocking: oscillator and nibble clock run at clk/2, converter clock at clk/4
  localparam int CLK_PERIOD_NS = 40;
  localparam int NIBBLE_DIV = 2;
  localparam int FADC_DIV = 2 * NIBBLE_DIV;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic clk_synth;
    logic tx_converter;
    logic tx_digital;
    logic reference;
    logic conv_common_mode;
    logic converter;
    logic amp_bias;
    logic rx_amp;
  } mfe_pd_s;

  typedef enum {SPI_IDLE, SPI_HEADER, SPI_DATA} mfe_spi_e;
endpackage : mfe_pkg
`default_nettype wire

// ---- hw/mfe_config.sv ----
/*
  Modem front end digital port and configuration registers, plus the transmit FIFO.
  Assumes all pin inputs are asynchronous to clk and toggle well below clk/4,
  and that the converter side runs on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module mfe_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mfe_fifo

// Notes on behaviour
// - Mode pin low half duplex, high full
// - Defaults pin picks power-up register set
// - Half duplex: ten pins form bidirectional buffer
// - Full duplex: transmit nibbles on pins 1-6
// - Full duplex: receive nibbles on pins 7-12
// - Pin 13: buffer control in, sync out
// - Pin 14: transmit enable or transmit sync
// - Pin 15: sample clock or fast power-down
// - Receive clock pin: request in, clock out
// - First aux clock: converter clock divided 1-8
// - Second aux clock: oscillator divided 1-4
// - Aux register fields, divide-by-two defaults
// - Hardware reset input is active low
// - Register zero: four-wire, LSB first, reset
// - Power-down pin low applies register one
// - Power-down pin high applies register two
// - Half-duplex power register, defaults all ones
// - Transmit driver off delayed after enable drops
// - PLL register fields and defaults
// - Half duplex, defaults high: multiplier code 10
// - Gain strobe selects data or gain nibble
// - Six-bit receive gain port in both modes
// - Transmit enable selects active signal path
module mfe_config #(
  parameter int FIFO_DEPTH = mfe_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Strap and power pins
  input wire logic mode_pin,
  input wire logic config_pin,
  input wire logic power_down_pin,
  // Serial port
  input wire logic sclk,
  input wire logic sen_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdo_out,
  output logic sdo_oe,
  // Data pins, bit 11 is pin 1
  input wire logic [11:0] data_in,
  output logic [11:0] data_out,
  output logic [11:0] data_oe,
  // Dual-use pins
  input wire logic dir_sync_in,
  output logic dir_sync_out,
  output logic dir_sync_oe,
  input wire logic tx_enable_sync_in,
  input wire logic sample_clk_quiet_in,
  input wire logic receive_clock_pin_in,
  output logic receive_clock_pin_out,
  output logic receive_clock_pin_oe,
  input wire logic gain_strobe_in,
  input wire logic [5:0] receive_gain_port,
  // Converter side
  output logic [9:0] tx_word,
  output logic tx_word_valid,
  input wire logic tx_word_ready,
  input wire logic [9:0] rx_word,
  input wire logic rx_word_valid,
  output logic [5:0] rx_gain,
  output logic [5:0] tx_gain,
  output logic tx_overflow,
  // Power and clocks
  output mfe_pkg::mfe_pd_s block_power_down,
  output logic fast_transmit_power_down,
  output logic tx_path_power_down,
  output logic rx_path_power_down,
  output logic [7:0] pll_control,
  output logic first_aux_clock,
  output logic second_aux_clock
);
  localparam int SW = 29;
  logic [SW-1:0] s1_r, s2_r;
  logic [11:0] d_s;
  logic dir_s, transmit_path_enable_s, sclkq_s, rqclk_s, gain_s, mode_s, cfg_s, pd_s, sck_s, sen_s, sdi_s;
  logic [5:0] pga_s;
  logic hd, fd;
  logic sclkq_d_r, rqclk_d_r, sck_d_r;
  logic [7:0] regs_r [mfe_pkg::NUM_REGS];
  logic [4:0] base_r;
  logic fadc_tick, nib_tick;

  function automatic logic [7:0] reg_default(input logic full, input logic cfg, input logic [2:0] idx);
    logic both;
    both = full && cfg;
    case (idx)
      3'h2: reg_default = both ? mfe_pkg::DEF_PD_HIGH_ALL : mfe_pkg::DEF_PD_HIGH;
      3'h3: reg_default = mfe_pkg::DEF_HD_POWER;
      3'h4: reg_default = (!full && cfg) ? mfe_pkg::DEF_PLL_HD_CFG : mfe_pkg::DEF_PLL;
      3'h5: reg_default = both ? mfe_pkg::DEF_RECEIVE_CLOCK_PIN_ALL : mfe_pkg::DEF_ZERO;
      3'h6: reg_default = both ? mfe_pkg::DEF_AUX_ALL : mfe_pkg::DEF_AUX;
      default: reg_default = mfe_pkg::DEF_ZERO;
    endcase
  endfunction : reg_default

  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    case (a)
      mfe_pkg::REG_OPTIONS: reg_mask = mfe_pkg::MASK_OPTIONS;
      mfe_pkg::REG_PLL: reg_mask = mfe_pkg::MASK_PLL;
      mfe_pkg::REG_RECEIVE_CLOCK_PIN: reg_mask = mfe_pkg::MASK_RECEIVE_CLOCK_PIN;
      mfe_pkg::REG_PD_LOW, mfe_pkg::REG_PD_HIGH, mfe_pkg::REG_HD_POWER,
      mfe_pkg::REG_AUXCLK: reg_mask = mfe_pkg::MASK_FULL;
      default: reg_mask = mfe_pkg::DEF_ZERO;
    endcase
  endfunction : reg_mask

  // Every pin except rst_n passes two flops before use
  always_ff @(posedge clk) begin
    if (ce) begin
      s1_r <= {data_in, dir_sync_in, tx_enable_sync_in, sample_clk_quiet_in, receive_clock_pin_in,
               gain_strobe_in, receive_gain_port, mode_pin, config_pin, power_down_pin, sclk, sen_n, sdio_in};
      s2_r <= s1_r;
    end
  end
  assign {d_s, dir_s, transmit_path_enable_s, sclkq_s, rqclk_s, gain_s, pga_s, mode_s, cfg_s, pd_s, sck_s, sen_s, sdi_s} = s2_r;

  assign hd = !mode_s;
  assign fd = mode_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkq_d_r <= 1'b0;
      rqclk_d_r <= 1'b0;
      sck_d_r <= 1'b0;
      base_r <= '0;
    end else if (ce) begin
      sclkq_d_r <= sclkq_s;
      rqclk_d_r <= rqclk_s;
      sck_d_r <= sck_s;
      base_r <= base_r + 1'b1;
    end
  end
  assign fadc_tick = (base_r[1:0] == 2'b11);
  assign nib_tick = base_r[0];

  // Serial port
  mfe_pkg::mfe_spi_e st_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r, txsh_r, sh_nxt;
  logic rd_r;
  logic [1:0] nb_r;
  logic [4:0] addr_r, addr_nxt;
  logic wr_en, swrst_r, lsb, reload;
  logic [7:0] rd_data;

  assign lsb = regs_r[0][mfe_pkg::OPT_LSB_FIRST];
  assign sh_nxt = lsb ? {sdi_s, sh_r[7:1]} : {sh_r[6:0], sdi_s};
  assign wr_en = (st_r == mfe_pkg::SPI_DATA) && !rd_r && sck_s && !sck_d_r && (bit_r == 3'd7) && !sen_s;
  assign rd_data = (addr_nxt < 5'(mfe_pkg::NUM_REGS)) ? regs_r[addr_nxt[2:0]] : mfe_pkg::DEF_ZERO;

  // Multibyte walks down MSB first, up LSB first
  always_comb begin
    addr_nxt = addr_r;
    if (st_r == mfe_pkg::SPI_HEADER) begin
      addr_nxt = sh_nxt[4:0];
    end else if (st_r == mfe_pkg::SPI_DATA) begin
      addr_nxt = lsb ? addr_r + 5'd1 : addr_r - 5'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= mfe_pkg::SPI_IDLE;
      bit_r <= '0;
      sh_r <= '0;
      txsh_r <= '0;
      rd_r <= 1'b0;
      nb_r <= '0;
      addr_r <= '0;
      sdio_out <= 1'b0;
      sdo_out <= 1'b0;
    end else if (ce) begin
      if (sen_s) begin
        st_r <= mfe_pkg::SPI_IDLE;
        bit_r <= '0;
      end else if (sck_s && !sck_d_r) begin
        sh_r <= sh_nxt;
        bit_r <= bit_r + 3'd1;
        if (st_r == mfe_pkg::SPI_IDLE) begin
          st_r <= mfe_pkg::SPI_HEADER;
        end
        if (bit_r == 3'd7) begin
          txsh_r <= rd_data;
          addr_r <= addr_nxt;
          if (st_r == mfe_pkg::SPI_HEADER) begin
            // Shifter holds the header in natural order for both bit orders
            rd_r <= sh_nxt[7];
            nb_r <= sh_nxt[6:5];
            st_r <= mfe_pkg::SPI_DATA;
          end else if (nb_r == 2'd0) begin
            st_r <= mfe_pkg::SPI_IDLE;
          end else begin
            nb_r <= nb_r - 2'd1;
          end
        end
      end else if (!sck_s && sck_d_r && st_r == mfe_pkg::SPI_DATA && rd_r) begin
        sdio_out <= lsb ? txsh_r[0] : txsh_r[7];
        sdo_out <= lsb ? txsh_r[0] : txsh_r[7];
        txsh_r <= lsb ? {1'b0, txsh_r[7:1]} : {txsh_r[6:0], 1'b0};
      end
    end
  end

  // Read data lines driven only during a read's data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdio_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (ce) begin
      sdio_oe <= !sen_s && rd_r && st_r == mfe_pkg::SPI_DATA && !regs_r[0][mfe_pkg::OPT_FOUR_WIRE];
      sdo_oe <= !sen_s && rd_r && st_r == mfe_pkg::SPI_DATA && regs_r[0][mfe_pkg::OPT_FOUR_WIRE];
    end
  end

  // defaults on reset or software reset
  assign reload = !rst_n || swrst_r;
  always_ff @(posedge clk) begin
    if (ce) begin
      swrst_r <= rst_n && wr_en && (addr_r == mfe_pkg::REG_OPTIONS) && sh_nxt[mfe_pkg::OPT_SW_RESET];
      for (int i = 0; i < mfe_pkg::NUM_REGS; i++) begin
        if (reload) begin
          regs_r[i] <= reg_default(fd, cfg_s, 3'(i));
        end else if (wr_en && addr_r == 5'(i)) begin
          regs_r[i] <= sh_nxt & reg_mask(addr_r);
        end
      end
    end
  end

  // Transmit path into the FIFO
  logic push, f_ready, f_valid, f_pop, have_hi_r;
  logic [9:0] push_data, f_data;
  logic [5:0] hi_r, tx_nib;
  assign tx_nib = d_s[11:6];

  always_comb begin
    push = 1'b0;
    push_data = d_s[11:2];
    if (hd) begin
      // buffer sampled on sample clock rise
      push = transmit_path_enable_s && !dir_s && sclkq_s && !sclkq_d_r;
    end else if (nib_tick && !gain_s && !transmit_path_enable_s && have_hi_r) begin
      push = 1'b1;
      push_data = {hi_r, tx_nib[5:2]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      have_hi_r <= 1'b0;
      hi_r <= '0;
      tx_gain <= '0;
      tx_overflow <= 1'b0;
    end else if (ce) begin
      if (push && !f_ready) begin
        tx_overflow <= 1'b1;
      end
      if (fd && nib_tick) begin
        if (gain_s) begin
          tx_gain <= tx_nib;
        end else if (transmit_path_enable_s) begin
          hi_r <= tx_nib;
          have_hi_r <= 1'b1;
        end else begin
          have_hi_r <= 1'b0;
        end
      end
    end
  end

  mfe_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(push_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Output stage keeps converter outputs on flops
  assign f_pop = !tx_word_valid || tx_word_ready;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_word_valid <= 1'b0;
      tx_word <= '0;
    end else if (ce && f_pop) begin
      tx_word_valid <= f_valid;
      tx_word <= f_data;
    end
  end

  // Receive path
  logic [9:0] rx_hold_r;
  logic [5:0] lo_r;
  logic rx_phase_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_hold_r <= '0;
      lo_r <= '0;
      rx_phase_r <= 1'b0;
      data_out <= '0;
      data_oe <= '0;
      dir_sync_out <= 1'b0;
      dir_sync_oe <= 1'b0;
      rx_gain <= '0;
    end else if (ce) begin
      rx_gain <= pga_s;
      if (rx_word_valid) begin
        rx_hold_r <= rx_word;
      end
      dir_sync_oe <= fd;
      if (fd) begin
        data_oe <= 12'h03f;
        if (nib_tick) begin
          rx_phase_r <= !rx_phase_r;
          dir_sync_out <= !rx_phase_r;
          data_out[5:0] <= rx_phase_r ? lo_r : rx_hold_r[9:4];
          if (!rx_phase_r) begin
            lo_r <= {rx_hold_r[3:0], 2'b00};
          end
        end
      end else begin
        data_oe <= {{10{dir_s}}, 2'b00};
        dir_sync_out <= 1'b0;
        rx_phase_r <= 1'b0;
        if (rqclk_s && !rqclk_d_r) begin
          data_out <= {rx_hold_r, 2'b00};
        end
      end
    end
  end

  // Power control
  logic [4:0] off_cnt_r;
  logic [7:0] hdp;
  assign hdp = regs_r[3];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_power_down <= '0;
      fast_transmit_power_down <= 1'b0;
      tx_path_power_down <= 1'b0;
      rx_path_power_down <= 1'b0;
      off_cnt_r <= '0;
      pll_control <= '0;
    end else if (ce) begin
      pll_control <= regs_r[4];
      block_power_down <= pd_s ? regs_r[2] : regs_r[1];
      fast_transmit_power_down <= fd && sclkq_s;
      if (transmit_path_enable_s) begin
        off_cnt_r <= hdp[7:mfe_pkg::HDP_DELAY_LO];
      end else if (fadc_tick && off_cnt_r != 5'd0) begin
        off_cnt_r <= off_cnt_r - 5'd1;
      end
      tx_path_power_down <= hd && hdp[mfe_pkg::HDP_RX_BY_TRANSMIT_PATH_ENABLE] && hdp[mfe_pkg::HDP_TX_PD]
                            && !transmit_path_enable_s && off_cnt_r == 5'd0;
      rx_path_power_down <= hd && hdp[mfe_pkg::HDP_RX_BY_TRANSMIT_PATH_ENABLE] && hdp[mfe_pkg::HDP_RX_PD] && transmit_path_enable_s;
    end
  end

  // Clock outputs
  logic [1:0] d1, d2;
  logic osc_rx;
  logic [7:0] rxo, aux;
  assign rxo = regs_r[5];
  assign aux = regs_r[6];
  assign d1 = aux[mfe_pkg::AUX1_DIV_LO+:2];
  assign d2 = aux[mfe_pkg::AUX2_DIV_LO+:2];
  // Oscillator route taken when RXO_OSC_ROUTE is set; the other route also reads base_r[0]
  localparam int NIBBLE_SEL = 0;
  assign osc_rx = rxo[mfe_pkg::RXO_OSC_ROUTE] ? base_r[0] : base_r[NIBBLE_SEL];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      receive_clock_pin_out <= 1'b0;
      receive_clock_pin_oe <= 1'b0;
      first_aux_clock <= 1'b0;
      second_aux_clock <= 1'b0;
    end else if (ce) begin
      receive_clock_pin_oe <= fd;
      receive_clock_pin_out <= !rxo[mfe_pkg::RXO_DISABLE] && (osc_rx ^ rxo[mfe_pkg::RXO_INVERT]);
      first_aux_clock <= !aux[mfe_pkg::AUX1_DISABLE] && (base_r[3'd1 + {1'b0, d1}] ^ aux[mfe_pkg::AUX1_INVERT]);
      // oscillator divided, code 11 as four
      second_aux_clock <= !aux[mfe_pkg::AUX2_DISABLE]
                          && (base_r[(d2 == 2'b11) ? 3'd2 : {1'b0, d2}] ^ aux[mfe_pkg::AUX2_INVERT]);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_first_nibble;
    ce && fd && nib_tick && !rx_phase_r;
  endsequence
  sequence s_second_nibble;
    ce && fd && nib_tick && rx_phase_r;
  endsequence

  property p_fd_pins;
    (ce && fd) |=> (data_oe == 12'h03f) && receive_clock_pin_oe && dir_sync_oe;
  endproperty
  a_fd_pins: assert property (p_fd_pins) else $error("full duplex pin directions wrong");

  property p_hd_buffer;
    (ce && hd && dir_s) |=> (data_oe[11:2] == 10'h3ff) && (data_oe[1:0] == 2'b00) && !receive_clock_pin_oe;
  endproperty
  a_hd_buffer: assert property (p_hd_buffer) else $error("half duplex buffer not driven");

  property p_rx_sync;
    s_first_nibble |=> dir_sync_out && (data_out[5:0] == $past(rx_hold_r[9:4]));
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("first nibble or sync wrong");

  property p_rx_second;
    s_second_nibble |=> !dir_sync_out && (data_out[5:0] == $past(lo_r));
  endproperty
  a_rx_second: assert property (p_rx_second) else $error("second nibble wrong");

  property p_gain_nibble;
    (ce && fd && nib_tick && gain_s) |=> (tx_gain == $past(tx_nib)) && !$past(push);
  endproperty
  a_gain_nibble: assert property (p_gain_nibble) else $error("gain nibble not taken");

  property p_pd_select;
    ce |=> block_power_down == ($past(pd_s) ? $past(regs_r[2]) : $past(regs_r[1]));
  endproperty
  a_pd_select: assert property (p_pd_select) else $error("power-down register not applied");

  property p_tx_off_delay;
    (ce && $rose(tx_path_power_down)) |-> ($past(off_cnt_r) == 5'd0) && !$past(transmit_path_enable_s);
  endproperty
  a_tx_off_delay: assert property (p_tx_off_delay) else $error("transmit powered down early");

  property p_sw_reset;
    (ce && swrst_r && fd && cfg_s) |=> (regs_r[0] == 8'h00) && (regs_r[6] == 8'h55) && (regs_r[2] == 8'hff);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset defaults wrong");

  property p_aux_disable;
    (ce && aux[mfe_pkg::AUX1_DISABLE] && aux[mfe_pkg::AUX2_DISABLE]) |=> !first_aux_clock && !second_aux_clock;
  endproperty
  a_aux_disable: assert property (p_aux_disable) else $error("disabled aux clock running");
endmodule : mfe_config
`default_nettype wire
